//--- rtl/frs_params.svh
// Constants for the result status byte builder.
// Assumes inclusion from the package and the modules by bare name.
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH
`define FRS_LAST_SECTOR      8'hFF
`define FRS_BAD_TRACK        8'hFF
`define FRS_INDEX_LIMIT      2'h2
`define FRS_A_END_CYL        7
`define FRS_A_CRC            5
`define FRS_A_OVERRUN        4
`define FRS_A_NO_SECTOR      2
`define FRS_A_WRITE_BLOCKED  1
`define FRS_A_NO_MARK        0
`define FRS_B_CTRL_MARK      6
`define FRS_B_DATA_CRC       5
`define FRS_B_TRACK_MISMATCH 4
`define FRS_B_BAD_TRACK      1
`define FRS_B_NO_DATA_MARK   0
`define FRS_D_PROTECT        6
`define FRS_D_HOME           4
`define FRS_D_HEAD           2
`define FRS_D_CONST_MASK     8'h28
`define FRS_SEL_STAT_A       2'h1
`define FRS_SEL_STAT_B       2'h2
`define FRS_SEL_DRIVE        2'h3
`endif

//--- rtl/frs_pkg.sv
// Types for the result status byte builder.
// Assumes the constants header sits on the include path.
package frs_pkg;
    `include "frs_params.svh"
    typedef enum logic [2:0] {
        FRS_CMD_OTHER      = 3'h0,
        FRS_CMD_READ       = 3'h1,
        FRS_CMD_READ_DEL   = 3'h2,
        FRS_CMD_WRITE      = 3'h3,
        FRS_CMD_WRITE_DEL  = 3'h4,
        FRS_CMD_FORMAT     = 3'h5,
        FRS_CMD_READ_ID    = 3'h6,
        FRS_CMD_READ_TRACK = 3'h7
    } frs_cmd_t;
    typedef enum logic [1:0] {
        FRS_IDLE    = 2'h0,
        FRS_EXEC    = 2'h1,
        FRS_RESULT  = 2'h2
    } frs_phase_t;
endpackage

//--- rtl/frs_sync.sv
// Two-flop synchroniser for a bundle of drive-cable pins.
// Assumes the pins are asynchronous to ref_clk_i.
`timescale 1ns/1ps
module frs_sync #(
    parameter int W = 5
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    // Pins in, synchronised out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule

//--- rtl/frs_status.sv
// Builds the second, third and fourth result status bytes and presents
// them on a byte-wide read port during the result phase.
// Assumes the command sequencer supplies one-cycle event strobes from the
// same clock domain, and drive pins arrive asynchronously.
`timescale 1ns/1ps
`include "frs_params.svh"
module frs_status
    import frs_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Command sequencing from the controller core
    input  wire logic       cmd_start_i,
    input  wire logic [2:0] cmd_code_i,
    input  wire logic       cmd_done_i,
    input  wire logic       transfer_end_strobe_i,
    // Sector and track events from the disk engine
    input  wire logic       sector_advance_i,
    input  wire logic [7:0] sector_num_i,
    input  wire logic       id_crc_err_i,
    input  wire logic       data_crc_err_i,
    input  wire logic       service_late_i,
    input  wire logic       sector_not_found_i,
    input  wire logic       id_read_err_i,
    input  wire logic       sequence_err_i,
    input  wire logic       id_mark_found_i,
    input  wire logic       data_mark_missing_i,
    input  wire logic       deleted_mark_seen_i,
    input  wire logic       normal_mark_seen_i,
    input  wire logic       id_valid_i,
    input  wire logic [7:0] id_track_i,
    input  wire logic [7:0] cur_track_i,
    // Drive cable pins
    input  wire logic       index_pulse_in_n_i,
    input  wire logic       protect_pin_i,
    input  wire logic       home_track_pin_i,
    input  wire logic       head_pick_pin_i,
    input  wire logic       drive_pick1_pin_i,
    input  wire logic       drive_pick0_pin_i,
    // Result byte read port
    input  wire logic [1:0] result_sel_i,
    input  wire logic       result_rd_i,
    output logic [7:0]      result_data_o,
    output logic            result_valid_o
);
    logic [4:0] pins_sync;
    logic       index_n_sync;
    logic       index_n_prev;
    logic       protect_prev;
    logic [1:0] index_cnt_reg;
    frs_phase_t phase_reg;
    frs_cmd_t   cmd_reg;
    logic       crc_fault_flag;
    logic       end_cyl_flag;
    logic       overrun_flag;
    logic       missing_sector_flag;
    logic       write_blocked_flag;
    logic       id_sync_absent_flag;
    logic       ctrl_mark_flag;
    logic       payload_crc_flag;
    logic       track_mismatch_flag;
    logic       bad_track_flag;
    logic       payload_sync_absent_flag;
    logic       clr;
    logic       is_write;
    logic       is_data_xfer;
    logic       end_no_tc;
    logic       tc_seen_reg;
    logic       id_mismatch;
    logic [7:0] stat_a;
    logic [7:0] stat_b;
    logic [7:0] stat_d;
    logic [7:0] result_next;

    frs_sync #(.W(6)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   ({index_pulse_in_n_i, protect_pin_i, home_track_pin_i,
                     head_pick_pin_i, drive_pick1_pin_i, drive_pick0_pin_i}),
        .sync_o    ({index_n_sync, pins_sync})
    );

    // Only an accepted start clears, so a clear never meets a set.
    assign clr          = cmd_start_i && (phase_reg != FRS_EXEC);
    assign is_write     = (cmd_reg == FRS_CMD_WRITE) ||
                          (cmd_reg == FRS_CMD_WRITE_DEL) ||
                          (cmd_reg == FRS_CMD_FORMAT);
    assign is_data_xfer = (cmd_reg == FRS_CMD_READ) ||
                          (cmd_reg == FRS_CMD_READ_DEL) ||
                          (cmd_reg == FRS_CMD_WRITE) ||
                          (cmd_reg == FRS_CMD_WRITE_DEL);
    assign end_no_tc    = cmd_done_i && is_data_xfer && !tc_seen_reg &&
                          !transfer_end_strobe_i;
    assign id_mismatch  = id_valid_i && (id_track_i != cur_track_i);

    // A command stays latched until the next start so results stay stable.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            phase_reg <= FRS_IDLE;
            cmd_reg   <= FRS_CMD_OTHER;
        end else begin
            case (phase_reg)
                FRS_IDLE, FRS_RESULT: begin
                    if (cmd_start_i) begin
                        phase_reg <= FRS_EXEC;
                        cmd_reg   <= frs_cmd_t'(cmd_code_i);
                    end
                end
                FRS_EXEC: begin
                    if (cmd_done_i) begin
                        phase_reg <= FRS_RESULT;
                    end
                end
                default: begin
                    phase_reg <= FRS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tc_seen_reg <= 1'b0;
        end else if (clr) begin
            tc_seen_reg <= 1'b0;
        end else if (transfer_end_strobe_i && phase_reg == FRS_EXEC) begin
            tc_seen_reg <= 1'b1;
        end
    end

    // Index pulses count falling edges of the active-low pin.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            // Matches the synchroniser's reset value, so no false edge
            // is seen while the synced pin climbs to its idle level.
            index_n_prev  <= 1'b0;
            protect_prev  <= 1'b0;
            index_cnt_reg <= 2'h0;
        end else begin
            index_n_prev <= index_n_sync;
            protect_prev <= pins_sync[4];
            if (clr || id_mark_found_i) begin
                index_cnt_reg <= 2'h0;
            end else if (phase_reg == FRS_EXEC && index_n_prev &&
                         !index_n_sync &&
                         index_cnt_reg != `FRS_INDEX_LIMIT) begin
                index_cnt_reg <= index_cnt_reg + 2'h1;
            end
        end
    end

    // Every flag is set only during execution; the clear comes with the
    // start strobe, which never coincides with an execution-phase event.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || clr) begin
            end_cyl_flag        <= 1'b0;
            crc_fault_flag      <= 1'b0;
            overrun_flag        <= 1'b0;
            missing_sector_flag <= 1'b0;
            write_blocked_flag  <= 1'b0;
            id_sync_absent_flag <= 1'b0;
        end else if (phase_reg == FRS_EXEC) begin
            if (sector_advance_i && sector_num_i == `FRS_LAST_SECTOR)
                end_cyl_flag <= 1'b1;
            if (end_no_tc)
                end_cyl_flag <= 1'b1;
            if (id_crc_err_i || data_crc_err_i)
                crc_fault_flag <= 1'b1;
            if (service_late_i)
                overrun_flag <= 1'b1;
            if ((sector_not_found_i && (cmd_reg == FRS_CMD_READ ||
                                        cmd_reg == FRS_CMD_READ_DEL)) ||
                (id_read_err_i && cmd_reg == FRS_CMD_READ_ID) ||
                (sequence_err_i && cmd_reg == FRS_CMD_READ_TRACK))
                missing_sector_flag <= 1'b1;
            if (is_write && pins_sync[4] && !protect_prev)
                write_blocked_flag <= 1'b1;
            if ((index_n_prev && !index_n_sync &&
                 index_cnt_reg == `FRS_INDEX_LIMIT - 2'h1) ||
                data_mark_missing_i)
                id_sync_absent_flag <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || clr) begin
            ctrl_mark_flag           <= 1'b0;
            payload_crc_flag         <= 1'b0;
            track_mismatch_flag      <= 1'b0;
            bad_track_flag           <= 1'b0;
            payload_sync_absent_flag <= 1'b0;
        end else if (phase_reg == FRS_EXEC) begin
            if ((cmd_reg == FRS_CMD_READ && deleted_mark_seen_i) ||
                (cmd_reg == FRS_CMD_READ_DEL && normal_mark_seen_i))
                ctrl_mark_flag <= 1'b1;
            if (data_crc_err_i)
                payload_crc_flag <= 1'b1;
            if (id_mismatch)
                track_mismatch_flag <= 1'b1;
            if (id_mismatch && id_track_i == `FRS_BAD_TRACK)
                bad_track_flag <= 1'b1;
            if (data_mark_missing_i)
                payload_sync_absent_flag <= 1'b1;
        end
    end

    always_comb begin
        stat_a = 8'h00;
        stat_a[`FRS_A_END_CYL]       = end_cyl_flag;
        stat_a[`FRS_A_CRC]           = crc_fault_flag;
        stat_a[`FRS_A_OVERRUN]       = overrun_flag;
        stat_a[`FRS_A_NO_SECTOR]     = missing_sector_flag;
        stat_a[`FRS_A_WRITE_BLOCKED] = write_blocked_flag;
        stat_a[`FRS_A_NO_MARK]       = id_sync_absent_flag;
        stat_b = 8'h00;
        stat_b[`FRS_B_CTRL_MARK]      = ctrl_mark_flag;
        stat_b[`FRS_B_DATA_CRC]       = payload_crc_flag;
        stat_b[`FRS_B_TRACK_MISMATCH] = track_mismatch_flag;
        stat_b[`FRS_B_BAD_TRACK]      = bad_track_flag;
        stat_b[`FRS_B_NO_DATA_MARK]   = payload_sync_absent_flag;
        stat_d = `FRS_D_CONST_MASK;
        stat_d[`FRS_D_PROTECT] = pins_sync[4];
        stat_d[`FRS_D_HOME]    = pins_sync[3];
        stat_d[`FRS_D_HEAD]    = pins_sync[2];
        stat_d[1:0]            = pins_sync[1:0];
    end

    // The drive byte is also readable outside a result phase, since the
    // sense-drive command returns it without any execution.
    always_comb begin
        case (result_sel_i)
            `FRS_SEL_STAT_A: result_next = stat_a;
            `FRS_SEL_STAT_B: result_next = stat_b;
            `FRS_SEL_DRIVE:  result_next = stat_d;
            default:         result_next = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            result_data_o  <= 8'h00;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= 1'b0;
            if (result_rd_i && (phase_reg == FRS_RESULT ||
                                result_sel_i == `FRS_SEL_DRIVE)) begin
                result_data_o  <= result_next;
                result_valid_o <= 1'b1;
            end
        end
    end
endmodule

//--- testbench/frs_status_asserts.sv
// Checker for the result status byte builder, bound to frs_status.
// Assumes reads and pins change away from the rising clock edge.
`timescale 1ns/1ps
module frs_status_asserts (
    // Clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    // Read port and drive pins
    input wire logic [1:0] result_sel_i,
    input wire logic       result_rd_i,
    input wire logic [7:0] result_data_o,
    input wire logic       result_valid_o,
    input wire logic       protect_pin_i,
    input wire logic       home_track_pin_i,
    input wire logic       head_pick_pin_i,
    input wire logic       drive_pick1_pin_i,
    input wire logic       drive_pick0_pin_i
);
    logic [4:0] pins;
    logic [4:0] pins_reg;
    logic [2:0] calm_reg;
    assign pins = {protect_pin_i, home_track_pin_i, head_pick_pin_i,
                   drive_pick1_pin_i, drive_pick0_pin_i};
    // Pins mirror exactly only once they have sat still past the sync.
    always_ff @(posedge ref_clk_i) begin
        pins_reg <= pins;
        if (rst_i || pins != pins_reg) begin
            calm_reg <= 3'h0;
        end else if (calm_reg != 3'h7) begin
            calm_reg <= calm_reg + 3'h1;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    drive_read_a: assert property (result_rd_i && result_sel_i == 2'h3
        |=> result_valid_o) else $error("drive byte read not answered");
    valid_cause_a: assert property (result_valid_o
        |-> $past(result_rd_i)) else $error("valid without a read");
    data_hold_a: assert property (!result_valid_o
        |-> $stable(result_data_o)) else $error("data moved without read");
    sel_zero_a: assert property (result_valid_o &&
        $past(result_sel_i) == 2'h0 |-> result_data_o == 8'h00)
        else $error("select zero not zero");
    stat_a_fixed_a: assert property (result_valid_o &&
        $past(result_sel_i) == 2'h1 |-> (result_data_o & 8'h48) == 8'h00)
        else $error("unused status a bits set");
    stat_b_fixed_a: assert property (result_valid_o &&
        $past(result_sel_i) == 2'h2 |-> (result_data_o & 8'h8C) == 8'h00)
        else $error("unused status b bits set");
    drive_fixed_a: assert property (result_valid_o &&
        $past(result_sel_i) == 2'h3 |-> (result_data_o & 8'hA8) == 8'h28)
        else $error("drive byte fixed bits wrong");
    pin_mirror_a: assert property (result_valid_o &&
        $past(result_sel_i) == 2'h3 && calm_reg >= 3'h5 |-> result_data_o ==
        {1'b0, pins[4], 1'b1, pins[3], 1'b1, pins[2:0]})
        else $error("drive byte does not mirror pins");
endmodule
bind frs_status frs_status_asserts u_frs_status_asserts (.ref_clk_i,
    .rst_i, .result_sel_i, .result_rd_i, .result_data_o, .result_valid_o,
    .protect_pin_i, .home_track_pin_i, .head_pick_pin_i,
    .drive_pick1_pin_i, .drive_pick0_pin_i);

//--- testbench/frs_host_model.sv
// Host processor that reads result bytes from the status data port.
// Assumes requests are issued on falling edges of ref_clk_i.
`timescale 1ns/1ps
module frs_host_model (
    // Clock
    input  wire logic       ref_clk_i,
    // Read port
    input  wire logic [7:0] result_data_i,
    input  wire logic       result_valid_i,
    output logic      [1:0] result_sel_o,
    output logic            result_rd_o
);
    initial begin
        result_sel_o = 2'h0;
        result_rd_o = 1'b0;
    end
    // One-cycle read; the select is scrambled after use, as a real host
    // leaves no promise about it between reads.
    task automatic read_byte(input logic [1:0] sel, output logic got,
                             output logic [7:0] d);
        d = 8'hXX;
        got = 1'b0;
        @(negedge ref_clk_i);
        result_sel_o = sel;
        result_rd_o = 1'b1;
        @(negedge ref_clk_i);
        result_rd_o = 1'b0;
        result_sel_o = ~sel;
        repeat (3) begin
            if (!got && result_valid_i === 1'b1) begin
                got = 1'b1;
                d = result_data_i;
            end
            @(negedge ref_clk_i);
        end
    endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for frs_status with a host reading result bytes.
// Assumes a 10 MHz clock and inputs driven on the falling edge.
`timescale 1ns/1ps
module tb_top;
    import frs_pkg::*;
    logic       ref_clk_i, rst_i, cmd_start_i, cmd_done_i, tc_i;
    logic       sec_adv_i, id_valid_i, index_n_i, result_rd_i;
    logic       result_valid_o, got;
    logic [2:0] cmd_code_i;
    logic [7:0] sector_num_i, id_track_i, cur_track_i, result_data_o, d;
    logic [9:0] ev;
    logic [4:0] pins;
    logic [1:0] result_sel_i;
    int         n_mismatch, total_checks;
    // Code, stimulus kind, argument, expected status a, expected status b.
    logic [31:0] cases [23] = '{32'h10002000, 32'h11002020,
        32'h12001000, 32'h13000400, 32'h64000400, 32'h75000400,
        32'h16000101, 32'h17000040, 32'h28000040, 32'h18000000,
        32'h27000000, 32'h1AFF8000, 32'h1AFE0000, 32'h1B070010,
        32'h1BFF0012, 32'h1CFF0000, 32'h1D000100, 32'h3E000200,
        32'h4E000200, 32'h5E000200, 32'h1E000000, 32'h1F008000,
        32'h1D010000};
    frs_status u_frs_status (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .cmd_start_i(cmd_start_i), .cmd_code_i(cmd_code_i),
        .cmd_done_i(cmd_done_i), .transfer_end_strobe_i(tc_i),
        .sector_advance_i(sec_adv_i), .sector_num_i(sector_num_i),
        .id_crc_err_i(ev[0]), .data_crc_err_i(ev[1]),
        .service_late_i(ev[2]), .sector_not_found_i(ev[3]),
        .id_read_err_i(ev[4]), .sequence_err_i(ev[5]),
        .data_mark_missing_i(ev[6]), .deleted_mark_seen_i(ev[7]),
        .normal_mark_seen_i(ev[8]), .id_mark_found_i(ev[9]),
        .id_valid_i(id_valid_i), .id_track_i(id_track_i),
        .cur_track_i(cur_track_i), .index_pulse_in_n_i(index_n_i),
        .protect_pin_i(pins[4]), .home_track_pin_i(pins[3]),
        .head_pick_pin_i(pins[2]), .drive_pick1_pin_i(pins[1]),
        .drive_pick0_pin_i(pins[0]), .result_sel_i(result_sel_i),
        .result_rd_i(result_rd_i), .result_data_o(result_data_o),
        .result_valid_o(result_valid_o));
    frs_host_model u_host (.ref_clk_i(ref_clk_i),
        .result_data_i(result_data_o), .result_valid_i(result_valid_o),
        .result_sel_o(result_sel_i), .result_rd_o(result_rd_i));
    task automatic check_byte(input logic [7:0] act, input logic [7:0] exp);
        total_checks++;
        if (act !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: byte %h not %h", $time, act, exp);
        end
    endtask
    task automatic check_flag(input logic act, input logic exp);
        total_checks++;
        if (act !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: flag %b not %b", $time, act, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic start_cmd(input logic [2:0] code);
        @(negedge ref_clk_i);
        cmd_code_i = code;
        cmd_start_i = 1'b1;
        tick(1);
        cmd_start_i = 1'b0;
    endtask
    task automatic finish_cmd(input logic with_tc);
        cmd_done_i = 1'b1;
        tc_i = with_tc;
        tick(1);
        cmd_done_i = 1'b0;
        tc_i = 1'b0;
    endtask
    task automatic run_case(input logic [31:0] e);
        logic [3:0] k;
        k = e[27:24];
        start_cmd(e[30:28]);
        if (k < 4'hA) begin
            ev[k] = 1'b1;
        end else if (k == 4'hA) begin
            sector_num_i = e[23:16];
            sec_adv_i = 1'b1;
        end else if (k < 4'hD) begin
            id_track_i = e[23:16];
            cur_track_i = (k == 4'hB) ? 8'h05 : e[23:16];
            id_valid_i = 1'b1;
        end else if (k == 4'hD) begin
            // A set argument bit reports an ID mark between the pulses,
            // which must restart the index count.
            repeat (2) begin
                index_n_i = 1'b0;
                tick(2);
                index_n_i = 1'b1;
                tick(1);
                ev[9] = e[16];
                tick(1);
                ev[9] = 1'b0;
                tick(1);
            end
        end else if (k == 4'hE) begin
            pins[4] = 1'b1;
        end
        tick(1);
        ev = 10'h000;
        sec_adv_i = 1'b0;
        id_valid_i = 1'b0;
        tick(4);
        finish_cmd(k != 4'hF);
        pins[4] = 1'b0;
        u_host.read_byte(2'h1, got, d);
        check_byte(d, e[15:8]);
        u_host.read_byte(2'h2, got, d);
        check_byte(d, e[7:0]);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        n_mismatch++;
        $display("wrong value at %0t: watchdog expired", $time);
        print_verdict();
    end
    initial begin
        {rst_i, cmd_start_i, cmd_done_i, tc_i, sec_adv_i, id_valid_i} = 6'h20;
        {cmd_code_i, sector_num_i, id_track_i, cur_track_i} = 27'h0;
        {ev, pins, index_n_i} = 16'h0001;
        n_mismatch = 0;
        total_checks = 0;
        tick(12);
        rst_i = 1'b0;
        start_cmd(3'h1);
        u_host.read_byte(2'h1, got, d);
        check_flag(got, 1'b0);
        finish_cmd(1'b1);
        ev[2] = 1'b1;
        tick(1);
        ev = 10'h000;
        u_host.read_byte(2'h1, got, d);
        check_byte(d, 8'h00);
        u_host.read_byte(2'h0, got, d);
        check_byte(d, 8'h00);
        $display("refusal test done");
        foreach (cases[i]) run_case(cases[i]);
        $display("error flag test done");
        for (int i = 0; i < 32; i++) begin
            pins = i[4:0];
            tick(5);
            u_host.read_byte(2'h3, got, d);
            check_byte(d, {1'b0, pins[4], 1'b1, pins[3], 1'b1,
                           pins[2:0]});
        end
        $display("drive byte test done");
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        check_byte(result_data_o, 8'h00);
        u_host.read_byte(2'h2, got, d);
        check_flag(got, 1'b0);
        $display("reset test done");
        print_verdict();
    end
endmodule
